/* File: rtl/acc_conv_control.sv */
// Purpose: register bank and conversion sequencer of the acquisition chain
// Assumes: register port from the serial slave, same clock domain
// Notes: modulator bit stream arrives from the analog side as a pin
`timescale 1ns/10ps
`default_nettype none
module acc_conv_control (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [2:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic mod_bit_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rvalid_o,
  output logic busy_o,
  output logic trigger_o,
  output logic sample_tick_o,
  output acc_pkg::acc_analog_t analog_o
);

  acc_pkg::acc_state_all_t s_q;
  acc_pkg::acc_state_all_t s_d;
  logic mod_meta_q;
  logic mod_sync_q;
  logic samp_tick_q;

  // oversampling ratio 2^(3+n)
  function automatic logic [10:0] osr_len(input logic [2:0] sel);
    osr_len = 11'(11'h008 << sel);
  endfunction

  // elementary conversions 2^n
  function automatic logic [3:0] elc_len(input logic [1:0] sel);
    elc_len = 4'(4'h1 << sel);
  endfunction

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mod_meta_q <= 1'b0;
      mod_sync_q <= 1'b0;
    end else begin
      mod_meta_q <= mod_bit_i;
      mod_sync_q <= mod_meta_q;
    end
  end

  always_comb begin
    logic osc_tick;
    logic samp_tick;
    logic [6:0] samp_len;
    logic start_req;
    logic restart;
    logic wr;
    logic [7:0] rd;
    osc_tick = 1'b0;
    samp_tick = 1'b0;
    samp_len = 7'h00;
    start_req = 1'b0;
    restart = 1'b0;
    wr = 1'b0;
    rd = 8'h00;
    s_d = s_q;
    s_d.trigger = 1'b0;
    s_d.rvalid = 1'b0;

    // oscillator tick, then sample tick per frequency field
    osc_tick = (s_q.osc_cnt == acc_pkg::OSC_DIV - 4'h1);
    s_d.osc_cnt = osc_tick ? 4'h0 : s_q.osc_cnt + 4'h1;
    samp_len = 7'(7'h01 << (acc_pkg::SAMPLE_DIV_LOG_MIN + 3 -
                            int'(s_q.cfg.freq_g2[7:6])));
    samp_tick = 1'b0;
    if (osc_tick) begin
      if (s_q.samp_cnt >= samp_len - 7'h01) begin
        s_d.samp_cnt = 7'h00;
        samp_tick = 1'b1;
      end else begin
        s_d.samp_cnt = s_q.samp_cnt + 7'h01;
      end
    end

    // register writes
    wr = reg_wr_i;
    if (wr) begin
      case (reg_addr_i)
        acc_pkg::ADDR_CTRL: begin
          s_d.cfg.ctrl = reg_wdata_i & 8'h6e;
          start_req = reg_wdata_i[acc_pkg::CTRL_START_BIT];
          if (reg_wdata_i[acc_pkg::CTRL_CONTINUOUS_CONV_BIT_BIT] &&
              !s_q.cfg.ctrl[acc_pkg::CTRL_CONTINUOUS_CONV_BIT_BIT]) begin
            start_req = 1'b1;
          end
        end
        acc_pkg::ADDR_BIAS_EN: s_d.cfg.bias_en = reg_wdata_i;
        acc_pkg::ADDR_FREQ_G2: s_d.cfg.freq_g2 = reg_wdata_i;
        acc_pkg::ADDR_G1_G3: s_d.cfg.g1_g3 = reg_wdata_i;
        acc_pkg::ADDR_OFS3: s_d.cfg.ofs3 = reg_wdata_i & 8'h7f;
        acc_pkg::ADDR_MUX: begin
          if (reg_wdata_i[acc_pkg::MUX_DEF_BIT]) begin
            // restore every setting, restart the conversion, even from idle
            s_d.cfg.ctrl = acc_pkg::RST_CTRL;
            s_d.cfg.bias_en = acc_pkg::RST_BIAS_EN;
            s_d.cfg.freq_g2 = acc_pkg::RST_FREQ_G2;
            s_d.cfg.g1_g3 = acc_pkg::RST_G1_G3;
            s_d.cfg.ofs3 = acc_pkg::RST_OFS3;
            s_d.cfg.mux = acc_pkg::RST_MUX;
            restart = 1'b1;
          end else begin
            s_d.cfg.mux = reg_wdata_i & 8'h3f;
          end
        end
        default: ;
      endcase
    end

    // pending request is served in idle or as soon as the running conversion finishes
    if (start_req) begin
      s_d.pending = 1'b1;
    end

    // sequencer
    case (s_q.state)
      acc_pkg::ST_IDLE: begin
        if (start_req || s_q.pending) begin
          s_d.pending = 1'b0;
          s_d.state = acc_pkg::ST_CONV;
          s_d.osr_cnt = 11'h000;
          s_d.elc_cnt = 4'h0;
          s_d.accum = 16'h0000;
          s_d.ana.chop = 1'b0;
        end
      end
      acc_pkg::ST_CONV: begin
        // same timing whichever mode started it
        if (samp_tick) begin
          s_d.accum = s_q.accum + (mod_sync_q ^ s_q.ana.chop ?
                                   16'h0001 : 16'hffff);
          if (s_q.osr_cnt == osr_len(s_q.cfg.ctrl[4:2]) - 11'h001) begin
            s_d.osr_cnt = 11'h000;
            s_d.ana.chop = ~s_q.ana.chop;
            if (s_q.elc_cnt == elc_len(s_q.cfg.ctrl[6:5]) - 4'h1) begin
              s_d.state = acc_pkg::ST_DONE;
            end else begin
              s_d.elc_cnt = s_q.elc_cnt + 4'h1;
            end
          end else begin
            s_d.osr_cnt = s_q.osr_cnt + 11'h001;
          end
        end
      end
      acc_pkg::ST_DONE: begin
        // both bytes written in one edge
        s_d.result = s_q.accum;
        s_d.trigger = 1'b1;
        if (s_q.cfg.ctrl[acc_pkg::CTRL_CONTINUOUS_CONV_BIT_BIT] || s_q.pending) begin
          s_d.pending = start_req;
          s_d.state = acc_pkg::ST_CONV;
          s_d.osr_cnt = 11'h000;
          s_d.elc_cnt = 4'h0;
          s_d.accum = 16'h0000;
          s_d.ana.chop = 1'b0;
        end else begin
          s_d.state = acc_pkg::ST_IDLE;
        end
      end
      default: s_d.state = acc_pkg::ST_IDLE;
    endcase

    if (restart) begin
      s_d.state = acc_pkg::ST_CONV;
      s_d.pending = 1'b0;
      s_d.osr_cnt = 11'h000;
      s_d.elc_cnt = 4'h0;
      s_d.accum = 16'h0000;
      s_d.ana.chop = 1'b0;
    end

    // register reads, eight byte registers
    case (reg_addr_i)
      acc_pkg::ADDR_RES_LOW: rd = s_q.result[7:0];
      acc_pkg::ADDR_RES_HIGH: rd = s_q.result[15:8];
      acc_pkg::ADDR_CTRL: rd = s_q.cfg.ctrl;
      acc_pkg::ADDR_BIAS_EN: rd = s_q.cfg.bias_en;
      acc_pkg::ADDR_FREQ_G2: rd = s_q.cfg.freq_g2;
      acc_pkg::ADDR_G1_G3: rd = s_q.cfg.g1_g3;
      acc_pkg::ADDR_OFS3: rd = s_q.cfg.ofs3;
      acc_pkg::ADDR_MUX: begin
        rd = s_q.cfg.mux;
        rd[acc_pkg::MUX_BUSY_BIT] = (s_q.state != acc_pkg::ST_IDLE);
      end
      default: rd = 8'h00;
    endcase
    if (reg_rd_i) begin
      s_d.rdata = rd;
      s_d.rvalid = 1'b1;
    end

    // analog settings decoded from the registers
    s_d.ana.converter_bias_sel = s_d.cfg.bias_en[7:6];
    s_d.ana.amplifier_bias_sel = s_d.cfg.bias_en[5:4];
    s_d.ana.enable = s_d.cfg.bias_en[3:0];
    s_d.ana.stage1_gain_sel = s_d.cfg.g1_g3[7];
    s_d.ana.stage2_gain_sel = s_d.cfg.freq_g2[5:4];
    s_d.ana.stage2_offset_sel = s_d.cfg.freq_g2[3:0];
    s_d.ana.stage3_gain_sel = s_d.cfg.g1_g3[6:0];
    s_d.ana.stage3_offset_sel = s_d.cfg.ofs3[6:0];
    s_d.ana.input_select = s_d.cfg.mux[5:1];
    s_d.ana.reference_select = s_d.cfg.mux[0];
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
      s_q.cfg.ctrl <= acc_pkg::RST_CTRL;
      s_q.cfg.bias_en <= acc_pkg::RST_BIAS_EN;
      s_q.cfg.freq_g2 <= acc_pkg::RST_FREQ_G2;
      s_q.cfg.g1_g3 <= acc_pkg::RST_G1_G3;
      s_q.cfg.ofs3 <= acc_pkg::RST_OFS3;
      s_q.cfg.mux <= acc_pkg::RST_MUX;
      s_q.ana.converter_bias_sel <= acc_pkg::RST_BIAS_EN[7:6];
      s_q.ana.amplifier_bias_sel <= acc_pkg::RST_BIAS_EN[5:4];
      s_q.ana.stage3_gain_sel <= acc_pkg::RST_G1_G3[6:0];
      samp_tick_q <= 1'b0;
    end else begin
      s_q <= s_d;
      samp_tick_q <= (s_q.osc_cnt == acc_pkg::OSC_DIV - 4'h1) &&
                     (s_d.samp_cnt == 7'h00);
    end
  end

  assign reg_rdata_o = s_q.rdata;
  assign reg_rvalid_o = s_q.rvalid;
  assign busy_o = (s_q.state != acc_pkg::ST_IDLE) ? 1'b1 : 1'b0;
  assign trigger_o = s_q.trigger;
  assign sample_tick_o = samp_tick_q;
  assign analog_o = s_q.ana;

endmodule
`default_nettype wire

/* File: rtl/acc_pkg.sv */
// Purpose: constants and types for the acquisition chain conversion control
// Assumes: 40 MHz system clock standing in for the 4 MHz oscillator
// Notes: registers reached over a simple byte-wide register port
package acc_pkg;
  localparam logic [2:0] ADDR_RES_LOW = 3'h0;
  localparam logic [2:0] ADDR_RES_HIGH = 3'h1;
  localparam logic [2:0] ADDR_CTRL = 3'h2;
  localparam logic [2:0] ADDR_BIAS_EN = 3'h3;
  localparam logic [2:0] ADDR_FREQ_G2 = 3'h4;
  localparam logic [2:0] ADDR_G1_G3 = 3'h5;
  localparam logic [2:0] ADDR_OFS3 = 3'h6;
  localparam logic [2:0] ADDR_MUX = 3'h7;
  // field positions
  localparam int CTRL_START_BIT = 7;
  localparam int CTRL_NELC_LSB = 5;
  localparam int CTRL_OSR_LSB = 2;
  localparam int CTRL_CONTINUOUS_CONV_BIT_BIT = 1;
  localparam int MUX_DEF_BIT = 6;
  localparam int MUX_BUSY_BIT = 7;
  // reset values (start, test and restore always read zero)
  localparam logic [7:0] RST_CTRL = 8'h28;
  localparam logic [7:0] RST_BIAS_EN = 8'hf0;
  localparam logic [7:0] RST_FREQ_G2 = 8'hc0;
  localparam logic [7:0] RST_G1_G3 = 8'h0c;
  localparam logic [7:0] RST_OFS3 = 8'h00;
  localparam logic [7:0] RST_MUX = 8'h00;
  // timing: 4 MHz oscillator tick from the 40 MHz clock
  localparam int CLK_HZ = 40000000;
  localparam int OSC_HZ = 4000000;
  localparam logic [3:0] OSC_DIV = 4'(CLK_HZ / OSC_HZ);
  // sample tick divides the oscillator by 8,16,32,64 for codes 11..00
  localparam int SAMPLE_DIV_LOG_MIN = 3;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CONV = 2'b01,
    ST_DONE = 2'b10
  } acc_state_t;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] bias_en;
    logic [7:0] freq_g2;
    logic [7:0] g1_g3;
    logic [7:0] ofs3;
    logic [7:0] mux;
  } acc_cfg_t;

  typedef struct packed {
    logic [1:0] converter_bias_sel;
    logic [1:0] amplifier_bias_sel;
    logic [3:0] enable;
    logic stage1_gain_sel;
    logic [1:0] stage2_gain_sel;
    logic [3:0] stage2_offset_sel;
    logic [6:0] stage3_gain_sel;
    logic [6:0] stage3_offset_sel;
    logic [4:0] input_select;
    logic reference_select;
    logic chop;
  } acc_analog_t;

  typedef struct packed {
    acc_state_t state;
    acc_cfg_t cfg;
    logic [15:0] result;
    logic pending;
    logic [3:0] osc_cnt;
    logic [6:0] samp_cnt;
    logic [10:0] osr_cnt;
    logic [3:0] elc_cnt;
    logic [15:0] accum;
    logic trigger;
    logic [7:0] rdata;
    logic rvalid;
    acc_analog_t ana;
  } acc_state_all_t;
endpackage

/* File: tb/acc_chk.sv */
// Purpose: port checker for the conversion control block
// Assumes: one clock domain, async active-low reset
// Notes: bound to every instance of the block
`timescale 1ns/10ps
`default_nettype none
module acc_chk (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [2:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic reg_rvalid_o,
  input wire logic busy_o,
  input wire logic trigger_o,
  input wire acc_pkg::acc_analog_t analog_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  wire logic rd_c = reg_rd_i && reg_addr_i == acc_pkg::ADDR_CTRL;
  wire logic rd_m = reg_rd_i && reg_addr_i == acc_pkg::ADDR_MUX;
  wire logic wr_c = reg_wr_i && reg_addr_i == acc_pkg::ADDR_CTRL;
  wire logic wr_m = reg_wr_i && reg_addr_i == acc_pkg::ADDR_MUX;
  property p_rv;
    reg_rd_i |=> reg_rvalid_o;
  endproperty
  a_rv: assert property (p_rv) else $error("no read answer");
  property p_rv_src;
    reg_rvalid_o |-> $past(reg_rd_i);
  endproperty
  a_rv_src: assert property (p_rv_src) else $error("stray answer");
  property p_busy_rd;
    rd_m |=> reg_rdata_o[7] == $past(busy_o);
  endproperty
  a_busy_rd: assert property (p_busy_rd) else $error("busy bit");
  property p_ctrl0;
    rd_c |=> !reg_rdata_o[7] && !reg_rdata_o[0];
  endproperty
  a_ctrl0: assert property (p_ctrl0) else $error("ctrl bits");
  property p_rst0;
    rd_m |=> !reg_rdata_o[6];
  endproperty
  a_rst0: assert property (p_rst0) else $error("restore bit");
  property p_trig;
    trigger_o |=> !trigger_o;
  endproperty
  a_trig: assert property (p_trig) else $error("trigger width");
  property p_start;
    wr_c && reg_wdata_i[7] && !busy_o |-> ##[1:3] busy_o;
  endproperty
  a_start: assert property (p_start) else $error("no start");
  property p_restore;
    wr_m && reg_wdata_i[6] |-> ##[1:3]
      (busy_o && analog_o.stage3_gain_sel == 7'h0c);
  endproperty
  a_restore: assert property (p_restore) else $error("restore");
  c_trig: cover property (trigger_o);
  c_start: cover property (wr_c && reg_wdata_i[7]);
  c_restore: cover property (wr_m && reg_wdata_i[6]);
endmodule
bind acc_conv_control acc_chk u_chk (.clock_i, .rst_n_i, .reg_wr_i,
  .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .reg_rvalid_o,
  .busy_o, .trigger_o, .analog_o);
`default_nettype wire

/* File: tb/acc_conv_control_bench.sv */
// Purpose: register-level test of the conversion control block
// Assumes: sample tick of 80 clocks at the fastest rate
// Notes: modulator bit held constant so results are exact
`timescale 1ns/10ps
`default_nettype none
module acc_conv_control_bench;
  import acc_pkg::*;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic mod_bit_i = 1'b1;
  logic wr, rd, rv, busy, trig, fail, tick;
  logic [2:0] addr;
  logic [7:0] wd, rdat, v;
  acc_analog_t ana;
  int num_errors = 0;
  int total_checks = 0;
  int n;
  int ticks;
  localparam logic [7:0] RV [5] = '{RST_CTRL, RST_BIAS_EN, RST_FREQ_G2,
    RST_G1_G3, RST_OFS3};
  localparam logic [7:0] CV [5] = '{8'h00, 8'h9b, 8'h6d, 8'h8f, 8'h55};
  always #12.5 clock_i = ~clock_i;
  acc_host_model u_host (.clock_i, .reg_rvalid_i(rv), .reg_rdata_i(rdat),
    .reg_wr_o(wr), .reg_rd_o(rd), .reg_addr_o(addr), .reg_wdata_o(wd),
    .fail_o(fail));
  acc_conv_control dut (.clock_i, .rst_n_i, .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_addr_i(addr), .reg_wdata_i(wd), .mod_bit_i, .reg_rdata_o(rdat),
    .reg_rvalid_o(rv), .busy_o(busy), .trigger_o(trig),
    .sample_tick_o(tick), .analog_o(ana));
  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic rchk(input logic [2:0] a, input logic [7:0] e);
    u_host.rd(a, v);
    chk({8'h00, v}, {8'h00, e});
  endtask
  task automatic wait_trig(output int c);
    c = 0;
    ticks = 0;
    do begin
      @(posedge clock_i);
      c++;
      if (tick === 1'b1) ticks++;
    end while (trig !== 1'b1 && c < 20000);
    if (c == 20000) begin
      num_errors++;
      complete_run();
    end
  endtask
  // conversion length within one eighth of it plus 20 clocks of start-up slack
  task automatic span(input int c, input int e);
    chk({15'h0, c > e - e / 8 - 20 && c < e + e / 8 + 20}, 16'h1);
  endtask
  always @(posedge fail) begin
    num_errors++;
    complete_run();
  end
  initial begin
    repeat (5) @(posedge clock_i);
    rst_n_i <= 1'b1;
    for (int i = 0; i < 5; i++) rchk(3'(i + 2), RV[i]);
    u_host.wr(ADDR_CTRL, 8'h81);
    rchk(ADDR_CTRL, 8'h00);
    rchk(ADDR_MUX, 8'h80);
    wait_trig(n);
    span(n, 640);
    // one sample tick may fall before the wait begins
    chk({15'h0, ticks >= 7 && ticks <= 9}, 16'h1);
    rchk(ADDR_RES_LOW, 8'h08);
    rchk(ADDR_RES_HIGH, 8'h00);
    rchk(ADDR_MUX, 8'h00);
    u_host.wr(ADDR_CTRL, 8'ha0);
    wait_trig(n);
    span(n, 1280);
    rchk(ADDR_RES_LOW, 8'h00);
    $display("test single done");
    u_host.wr(ADDR_CTRL, 8'h80);
    u_host.wr(ADDR_CTRL, 8'h80);
    wait_trig(n);
    wait_trig(n);
    span(n, 640);
    repeat (20) @(posedge clock_i);
    rchk(ADDR_MUX, 8'h00);
    $display("test queued done");
    mod_bit_i <= 1'b0;
    u_host.wr(ADDR_CTRL, 8'h02);
    wait_trig(n);
    wait_trig(n);
    span(n, 640);
    rchk(ADDR_RES_LOW, 8'hf8);
    rchk(ADDR_RES_HIGH, 8'hff);
    rchk(ADDR_CTRL, 8'h02);
    u_host.wr(ADDR_CTRL, 8'h00);
    wait_trig(n);
    repeat (20) @(posedge clock_i);
    rchk(ADDR_MUX, 8'h00);
    $display("test continuous done");
    u_host.wr(ADDR_RES_LOW, 8'h5a);
    for (int i = 1; i < 5; i++) u_host.wr(3'(i + 2), CV[i]);
    u_host.wr(ADDR_MUX, 8'h3f);
    rchk(ADDR_RES_LOW, 8'hf8);
    for (int i = 1; i < 5; i++) rchk(3'(i + 2), CV[i]);
    rchk(ADDR_MUX, 8'h3f);
    chk(16'(ana.converter_bias_sel), 16'h2);
    chk(16'(ana.amplifier_bias_sel), 16'h1);
    chk(16'(ana.enable), 16'hb);
    chk(16'(ana.stage2_gain_sel), 16'h2);
    chk(16'(ana.stage2_offset_sel), 16'hd);
    chk(16'(ana.stage1_gain_sel), 16'h1);
    chk(16'(ana.stage3_gain_sel), 16'h0f);
    chk(16'(ana.stage3_offset_sel), 16'h55);
    chk(16'(ana.input_select), 16'h1f);
    chk(16'(ana.reference_select), 16'h1);
    u_host.wr(ADDR_CTRL, 8'h80);
    wait_trig(n);
    span(n, 2560);
    $display("test settings done");
    u_host.wr(ADDR_CTRL, 8'h80);
    repeat (100) @(posedge clock_i);
    u_host.wr(ADDR_MUX, 8'h40);
    rchk(ADDR_MUX, 8'h80);
    for (int i = 0; i < 5; i++) rchk(3'(i + 2), RV[i]);
    wait_trig(n);
    span(n, 5120);
    $display("test restore done");
    complete_run();
  end
endmodule
`default_nettype wire

/* File: tb/acc_host_model.sv */
// Purpose: host side of the register port
// Assumes: strobes launched just after a rising edge
// Notes: idle address and data show the inverse of the last value
`timescale 1ns/10ps
`default_nettype none
module acc_host_model (
  input wire logic clock_i,
  input wire logic reg_rvalid_i,
  input wire logic [7:0] reg_rdata_i,
  output logic reg_wr_o = 1'b0,
  output logic reg_rd_o = 1'b0,
  output logic [2:0] reg_addr_o = 3'h0,
  output logic [7:0] reg_wdata_o = 8'h00,
  output logic fail_o = 1'b0
);
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock_i);
    reg_wr_o <= 1'b1;
    reg_addr_o <= a;
    reg_wdata_o <= d;
    @(posedge clock_i);
    reg_wr_o <= 1'b0;
    reg_addr_o <= ~a;
    reg_wdata_o <= ~d;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    int n;
    @(posedge clock_i);
    reg_rd_o <= 1'b1;
    reg_addr_o <= a;
    @(posedge clock_i);
    reg_rd_o <= 1'b0;
    reg_addr_o <= ~a;
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while (reg_rvalid_i !== 1'b1 && n < 4);
    d = reg_rdata_i;
    if (n == 4) fail_o <= 1'b1;
  endtask
endmodule
`default_nettype wire
